/* hw/spl_loopback.v */
// Line loopback path with jitter FIFO for one serial port
// Behaviour
// - Loopback enable bit per port turns line loopback on or off.
// - With loopback on, received code groups go straight to the same transmitter.
// - No clock compensation insert or delete; only a small jitter FIFO buffers.
// - Valid code groups decoding to legal control characters pass unchanged.
// - Code groups decoding to illegal controls with MSB zero also pass unaltered.
`timescale 1ns/1ps
`default_nettype none
`include "spl_loopback_map.vh"

module spl_fifo #(
   parameter WIDTH = `SPL_CODE_W,
   parameter DEPTH = `SPL_FIFO_DEPTH,
   parameter AW    = `SPL_FIFO_AW
) (
   input  wire             clk,       // Core clock
   input  wire             rst_n,     // Synchronous reset, active low
   input  wire             flush,     // Empty the buffer
   input  wire [WIDTH-1:0] in_data,   // Write data
   input  wire             in_valid,  // Write request
   output wire             in_ready,  // Room available
   output reg  [WIDTH-1:0] out_data,  // Read data, registered
   output reg              out_valid, // Read data valid
   input  wire             out_ready, // Drain side accepts
   output wire [AW:0]      level      // Occupancy
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wptr_reg;
   reg [AW:0]      rptr_reg;
   wire            full;
   wire            empty;
   wire            do_wr;
   wire            do_rd;

   // Pointer arithmetic with wrap bit for honest full and empty
   assign level    = wptr_reg - rptr_reg;
   assign full     = (level == DEPTH);
   assign empty    = (level == {(AW+1){1'b0}});
   assign in_ready = ~full;
   assign do_wr    = in_valid & ~full;
   assign do_rd    = ~empty & (~out_valid | out_ready);

   // Storage, no reset needed on data
   always @(posedge clk) begin
      if (do_wr) begin
         mem[wptr_reg[AW-1:0]] <= in_data;
      end
   end

   // Pointers and output register
   always @(posedge clk) begin
      if (!rst_n || flush) begin
         wptr_reg  <= {(AW+1){1'b0}};
         rptr_reg  <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
         out_data  <= {WIDTH{1'b0}};
      end else begin
         if (do_wr) begin
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (do_rd) begin
            out_data  <= mem[rptr_reg[AW-1:0]];
            out_valid <= 1'b1;
            rptr_reg  <= rptr_reg + 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule

module spl_loopback #(
   parameter WIDTH = `SPL_CODE_W,
   parameter DEPTH = `SPL_FIFO_DEPTH,
   parameter AW    = `SPL_FIFO_AW,
   parameter FILL  = `SPL_FILL_LEVEL
) (
   input  wire             CLOCK,          // Core clock, 100 MHz
   input  wire             RSTN,           // Synchronous reset, active low
   input  wire             LINE_LOOPBACK_ENABLE, // Port loopback enable level
   input  wire             RX_CLK,         // Recovered receive clock
   input  wire [WIDTH-1:0] RX_CODE,        // Received code group, stable at RX_CLK rise
   input  wire [WIDTH-1:0] TX_CODE_IN,     // Normal transmit code group
   input  wire             TX_VALID_IN,    // Normal transmit valid
   output wire             TX_READY_IN,    // Normal traffic accepted
   output reg  [WIDTH-1:0] TX_CODE,        // Code group to serial transmitter
   output reg              TX_VALID,       // Transmit code valid
   input  wire             TX_READY,       // Transmitter accepts a code
   output reg              OVERRUN,        // Loop FIFO overran, sticky
   output reg              UNDERRUN        // Loop FIFO ran dry, sticky
);
   localparam ST_NORMAL = 3'b001;
   localparam ST_FILL   = 3'b010;
   localparam ST_LOOP   = 3'b100;

   reg [2:0]       state_reg;
   reg [2:0]       state_next;
   reg             en_s1_reg;
   reg             en_s2_reg;
   reg             clk_s1_reg;
   reg             clk_s2_reg;
   reg             clk_s3_reg;
   reg [WIDTH-1:0] code_s1_reg;
   reg [WIDTH-1:0] code_s2_reg;
   wire            rx_edge;
   wire            loop_en;
   wire            fifo_in_ready;
   wire [WIDTH-1:0] fifo_data;
   wire            fifo_valid;
   wire            fifo_ready;
   wire [AW:0]     fifo_level;

   // Two-flop synchronisers for the loopback enable, recovered clock and received code inputs
   always @(posedge CLOCK) begin
      if (!RSTN) begin
         en_s1_reg   <= 1'b0;
         en_s2_reg   <= 1'b0;
         clk_s1_reg  <= 1'b0;
         clk_s2_reg  <= 1'b0;
         clk_s3_reg  <= 1'b0;
         code_s1_reg <= `SPL_RST_CODE;
         code_s2_reg <= `SPL_RST_CODE;
      end else begin
         en_s1_reg   <= LINE_LOOPBACK_ENABLE;
         en_s2_reg   <= en_s1_reg;
         clk_s1_reg  <= RX_CLK;
         clk_s2_reg  <= clk_s1_reg;
         clk_s3_reg  <= clk_s2_reg;
         code_s1_reg <= RX_CODE;
         code_s2_reg <= code_s1_reg;
      end
   end

   assign loop_en = en_s2_reg;
   // Rise of the recovered clock; data lags it by the same two flops
   assign rx_edge = clk_s2_reg & ~clk_s3_reg;

   // small jitter FIFO, no insert or delete
   spl_fifo #(
      .WIDTH (WIDTH),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_fifo (
      .clk       (CLOCK),
      .rst_n     (RSTN),
      .flush     (state_reg == ST_NORMAL),
      .in_data   (code_s2_reg),
      .in_valid  (rx_edge & (state_reg != ST_NORMAL)),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready),
      .level     (fifo_level)
   );

   // Drain only once centred, so jitter both ways is absorbed
   assign fifo_ready  = (state_reg == ST_LOOP) & (~TX_VALID | TX_READY);
   // normal traffic only when not looping
   assign TX_READY_IN = (state_reg == ST_NORMAL) & (~TX_VALID | TX_READY);

   // Mode sequencing
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_NORMAL: begin
            if (loop_en) begin
               state_next = ST_FILL;
            end
         end
         ST_FILL: begin
            if (!loop_en) begin
               state_next = ST_NORMAL;
            end else if (fifo_level >= FILL) begin
               state_next = ST_LOOP;
            end
         end
         ST_LOOP: begin
            if (!loop_en) begin
               state_next = ST_NORMAL;
            end
         end
         default: begin
            state_next = ST_NORMAL;
         end
      endcase
   end

   // Transmit output register; code groups pass bit for bit
   always @(posedge CLOCK) begin
      if (!RSTN) begin
         state_reg <= ST_NORMAL;
         TX_CODE   <= `SPL_RST_CODE;
         TX_VALID  <= 1'b0;
         OVERRUN   <= 1'b0;
         UNDERRUN  <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (~TX_VALID | TX_READY) begin
            if (state_reg == ST_LOOP) begin
               // no decode, so illegal controls kept
               TX_CODE  <= fifo_data;
               TX_VALID <= fifo_valid;
            end else if (state_reg == ST_NORMAL) begin
               TX_CODE  <= TX_CODE_IN;
               TX_VALID <= TX_VALID_IN;
            end else begin
               TX_VALID <= 1'b0;
            end
         end
         // mismatch flagged; cleared by leaving loopback
         if (state_reg == ST_NORMAL) begin
            OVERRUN  <= 1'b0;
            UNDERRUN <= 1'b0;
         end else begin
            if (rx_edge & ~fifo_in_ready) begin
               OVERRUN <= 1'b1;
            end
            if ((state_reg == ST_LOOP) & TX_READY & ~fifo_valid) begin
               UNDERRUN <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* hw/spl_loopback_map.vh */
// Constants for the serial port line loopback block
`ifndef SPL_LOOPBACK_MAP_VH
`define SPL_LOOPBACK_MAP_VH
`define SPL_CODE_W        10
`define SPL_FIFO_DEPTH    8
`define SPL_FIFO_AW       3
`define SPL_RST_CODE      10'h000
`define SPL_FILL_LEVEL    4
`endif

/* tb/spl_partner.sv */
// Remote link partner model
`timescale 1ns/1ps
`default_nettype none
module spl_partner (
   input  wire logic  run,     // Frame in progress
   output logic       rx_clk,  // Link clock
   output logic [9:0] rx_code, // Code group out
   output integer     rises    // Clock rises so far
);
   initial rx_clk = 1'b0;
   initial rx_code = 10'h15a;
   initial rises = 0;
   // Same reference as transmit pace, 80 ns
   always #40 if (run || rx_clk) rx_clk = ~rx_clk;
   always @(negedge rx_clk) rx_code <= rx_code + 10'h0a5;
   always @(posedge rx_clk) rises <= rises + 1;
   // Line released: show inverse, never the old value
   always @(negedge run) rx_code <= ~rx_code;
endmodule
`default_nettype wire

/* tb/spl_props_properties.sv */
// Assertion checker for the line loopback block
`timescale 1ns/1ps
`default_nettype none
module spl_props (
   input wire logic       CLOCK,       // Core clock
   input wire logic       RSTN,        // Reset, low
   input wire logic       LINE_LOOPBACK_ENABLE, // Loop on
   input wire logic [9:0] TX_CODE_IN,  // Normal data
   input wire logic       TX_VALID_IN, // Normal valid
   input wire logic       TX_READY_IN, // Normal ready
   input wire logic [9:0] TX_CODE,     // Out data
   input wire logic       TX_VALID,    // Out valid
   input wire logic       TX_READY,    // Out ready
   input wire logic       OVERRUN,     // Overrun flag
   input wire logic       UNDERRUN     // Underrun flag
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   // Enable held long enough to pass the synchroniser
   sequence s_on; LINE_LOOPBACK_ENABLE [*5]; endsequence
   sequence s_off; !LINE_LOOPBACK_ENABLE [*5]; endsequence
   property p_pass; TX_VALID_IN && TX_READY_IN |=> TX_VALID && TX_CODE == $past(TX_CODE_IN);
   endproperty
   a_pass: assert property (p_pass) else $error("normal word lost");
   property p_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_CODE); endproperty
   a_hold: assert property (p_hold) else $error("stalled word changed");
   property p_refuse; s_on |-> !TX_READY_IN; endproperty
   a_refuse: assert property (p_refuse) else $error("normal taken in loop");
   property p_free; s_off ##0 !TX_VALID |-> TX_READY_IN; endproperty
   a_free: assert property (p_free) else $error("normal path blocked");
   // Idle normal path must not show received groups
   property p_quiet; s_off ##0 (!TX_VALID_IN && (TX_READY || !TX_VALID)) |=> !TX_VALID;
   endproperty
   a_quiet: assert property (p_quiet) else $error("word out of nowhere");
   // Flags drop once the loop has been left long enough to pass the synchroniser
   property p_clear; s_off |-> !OVERRUN && !UNDERRUN; endproperty
   a_clear: assert property (p_clear) else $error("flag kept after loop");
endmodule
bind spl_loopback spl_props u_spl_props (.CLOCK, .RSTN, .LINE_LOOPBACK_ENABLE,
   .TX_CODE_IN, .TX_VALID_IN, .TX_READY_IN, .TX_CODE, .TX_VALID, .TX_READY,
   .OVERRUN, .UNDERRUN);
`default_nettype wire

/* tb/test_spl_loopback.sv */
// Self-checking bench for the line loopback block
`timescale 1ns/1ps
`default_nettype none
module test_spl_loopback;
   logic       CLOCK = 1'b0;
   logic       RSTN = 1'b0;
   logic       LINE_LOOPBACK_ENABLE = 1'b0;
   logic [9:0] TX_CODE_IN = 10'h000;
   logic       TX_VALID_IN = 1'b0;
   logic       TX_READY = 1'b1;
   logic       run = 1'b0;
   logic       pace = 1'b0;
   wire        RX_CLK;
   wire [9:0]  RX_CODE;
   wire [9:0]  TX_CODE;
   wire        TX_READY_IN;
   wire        TX_VALID;
   wire        OVERRUN;
   wire        UNDERRUN;
   integer     rises;
   integer     cyc = 0;
   integer     failures = 0;
   integer     samples_checked = 0;
   logic [9:0] expq[$];
   always #5 CLOCK = ~CLOCK;
   spl_loopback u_spl_loopback (.CLOCK, .RSTN, .LINE_LOOPBACK_ENABLE, .RX_CLK, .RX_CODE,
      .TX_CODE_IN, .TX_VALID_IN, .TX_READY_IN, .TX_CODE, .TX_VALID, .TX_READY, .OVERRUN,
      .UNDERRUN);
   spl_partner u_spl_partner (.run(run), .rx_clk(RX_CLK), .rx_code(RX_CODE), .rises(rises));
   task check(input logic [9:0] seen, input logic [9:0] want);
      samples_checked = samples_checked + 1;
      if (seen !== want) begin
         failures = failures + 1;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task give_verdict;
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Transmit slots paced at the link rate; hang guard
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (pace)
         TX_READY <= (cyc % 8 == 0);
      if (cyc == 3000) begin
         failures = failures + 1;
         give_verdict;
      end
   end
   // Every accepted word must be the next one expected
   always @(negedge CLOCK) begin
      if (TX_VALID === 1'b1 && TX_READY === 1'b1)
         check(TX_CODE, expq.size() > 0 ? expq.pop_front() : ~TX_CODE);
   end
   // Normal word handshake, called on a rising edge
   task send(input logic [9:0] c);
      logic r;
      expq.push_back(c);
      TX_CODE_IN <= c;
      TX_VALID_IN <= 1'b1;
      r = 1'b0;
      while (r !== 1'b1) begin
         @(negedge CLOCK);
         r = TX_READY_IN;
         @(posedge CLOCK);
      end
   endtask
   // Back-to-back words, the second held by a stall, then a third
   task t_normal;
      send(10'h155);
      send(10'h2aa);
      TX_VALID_IN <= 1'b0;
      TX_READY <= 1'b0;
      repeat (4) @(posedge CLOCK);
      TX_READY <= 1'b1;
      send(10'h3c1);
      TX_VALID_IN <= 1'b0;
      repeat (3) @(posedge CLOCK);
   endtask
   // A 20-group frame looped at the shared rate
   task t_loop;
      logic [9:0] w;
      w = 10'h15a;
      repeat (20) begin
         expq.push_back(w);
         w = w + 10'h0a5;
      end
      LINE_LOOPBACK_ENABLE <= 1'b1;
      pace <= 1'b1;
      repeat (6) @(posedge CLOCK);
      run <= 1'b1;
      while (rises < 20) @(posedge CLOCK);
      run <= 1'b0;
      check({8'h00, OVERRUN, UNDERRUN}, 10'h000);
      while (expq.size() != 0) @(posedge CLOCK);
      repeat (4) @(posedge CLOCK);
      // Frame over and drained: the loop buffer has run dry
      check({8'h00, OVERRUN, UNDERRUN}, 10'h001);
      // Stop the pacer first so only one process drives the ready line per edge
      pace <= 1'b0;
      @(posedge CLOCK);
      TX_READY <= 1'b1;
      LINE_LOOPBACK_ENABLE <= 1'b0;
   endtask
   // Loop off: flags gone, received groups not sent
   task t_off;
      repeat (6) @(posedge CLOCK);
      check({8'h00, OVERRUN, UNDERRUN}, 10'h000);
      run <= 1'b1;
      send(10'h0f0);
      send(10'h30f);
      TX_VALID_IN <= 1'b0;
      while (rises < 24) @(posedge CLOCK);
      run <= 1'b0;
      repeat (20) @(posedge CLOCK);
   endtask
   initial begin
      repeat (6) @(posedge CLOCK);
      RSTN <= 1'b1;
      t_normal;
      t_loop;
      t_off;
      check(expq.size() == 0 ? 10'h000 : 10'h3ff, 10'h000);
      give_verdict;
   end
endmodule
`default_nettype wire
